//--- design/osf_pkg.sv
// shared constants and types for the output supervisor block
package osf_pkg;
  // register byte offsets
  localparam logic [7:0] OSF_CTRL      = 8'h00;
  localparam logic [7:0] OSF_VCMD      = 8'h04;
  localparam logic [7:0] OSF_VTRIM     = 8'h08;
  localparam logic [7:0] OSF_MRG_HI    = 8'h0C;
  localparam logic [7:0] OSF_MRG_LO    = 8'h10;
  localparam logic [7:0] OSF_VMAX      = 8'h14;
  localparam logic [7:0] OSF_OV_LIM    = 8'h18;
  localparam logic [7:0] OSF_UV_LIM    = 8'h1C;
  localparam logic [7:0] OSF_PG_ON     = 8'h20;
  localparam logic [7:0] OSF_PG_OFF    = 8'h24;
  localparam logic [7:0] OSF_RESP      = 8'h28;
  localparam logic [7:0] OSF_FREQ      = 8'h2C;
  localparam logic [7:0] OSF_STATUS    = 8'h30;
  localparam logic [7:0] OSF_TARGET    = 8'h34;
  localparam logic [7:0] OSF_OV_DLY    = 8'h38;
  // control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MRG  = 1;   // two bits: 0 none, 1 low, 2 high
  // response register fields
  localparam int RESP_OV   = 0;
  localparam int RESP_UV   = 2;
  localparam int RESP_OC   = 4;
  // voltage fault responses
  localparam logic [1:0] VR_IGNORE = 2'h0;
  localparam logic [1:0] VR_DELAY  = 2'h1;
  localparam logic [1:0] VR_LATCH  = 2'h2;
  localparam logic [1:0] VR_AUTO   = 2'h3;
  // current fault responses
  localparam logic [1:0] CR_IGNORE = 2'h0;
  localparam logic [1:0] CR_LATCH  = 2'h1;
  localparam logic [1:0] CR_HICCUP = 2'h2;
  localparam logic [5:0] RESP_RST  = {CR_HICCUP, VR_AUTO, VR_AUTO};
  // percent of nominal for derived defaults
  localparam int PCT_MRG_HI = 105;
  localparam int PCT_MRG_LO = 95;
  localparam int PCT_VMAX   = 110;
  localparam int PCT_OV     = 115;
  localparam int PCT_UV     = 85;
  localparam int PCT_PG_ON  = 90;
  localparam int PCT_PG_OFF = 85;
  localparam logic [15:0] VMAX_ABS_MV = 16'h157C;  // 5500 mV
  // timing
  localparam int  CLK_HZ        = 100_000_000;
  localparam int  HICCUP_MS     = 20;
  localparam int  HICCUP_CYC    = HICCUP_MS * (CLK_HZ / 1000);
  localparam int  SYNC_LOSS_US  = 20;
  localparam int  SYNC_LOSS_CYC = SYNC_LOSS_US * (CLK_HZ / 1_000_000);
  localparam logic [15:0] FREQ_RST   = 16'h00C8;   // internal period in cycles
  localparam logic [15:0] OV_DLY_RST = 16'h0064;
  // sticky status flags
  typedef struct packed {
    logic sync_lost;
    logic oc;
    logic uv;
    logic ov;
  } osf_flags_t;
endpackage

//--- design/osf_supervisor.sv
// output setpoint resolution, fault response, power good and sync selection
`timescale 1ns/1ps
`default_nettype none
module osf_supervisor
  import osf_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_CYC,
  parameter int SYNC_CYCLES   = SYNC_LOSS_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // power-up straps
  input  wire logic [15:0] strap_vout_mv,
  input  wire logic        nvm_vout_valid,
  input  wire logic [15:0] nvm_vout_mv,
  // analog sense and loop status
  input  wire logic [15:0] vout_meas_mv,
  input  wire logic        oc_detect,
  input  wire logic        ramp_done,
  input  wire logic        cal_done,
  input  wire logic        sync_in,
  // loop control
  output logic [15:0]      vout_target_mv,
  output logic             output_on,
  output logic             clk_sel_ext,
  output logic             sw_tick,
  // open-drain power good
  output logic             supply_ok_output_o,
  output logic             supply_ok_output_oe
);
  // refuse timing counts that the counters cannot hold
  if (HICCUP_CYCLES < 1 || SYNC_CYCLES < 2 || SYNC_CYCLES > 65535) begin : g_bad_timing
    $error("osf_supervisor: unsupported timing parameter");
  end

  function automatic logic [15:0] pct(input logic [15:0] v, input int p);
    logic [31:0] prod;
    prod = 32'(v) * 32'(p) / 32'd100;
    return prod[15:0];
  endfunction

  // registers
  logic        init_q;
  logic [31:0] prdata_q;
  logic [2:0]  ctrl_q;
  logic [15:0] strap_q, vcmd_q, vtrim_q, mhi_q, mlo_q, vmax_q;
  logic [15:0] ovl_q, uvl_q, pgon_q, pgoff_q, freq_q, ovdly_q;
  logic [5:0]  resp_q;
  logic        cmd_wr_q;
  osf_flags_t  flags_q;
  logic        en_d1_q;
  logic [1:0]  shut_q;         // latched shutdown, ov and uv
  logic [15:0] dly_q [2];
  logic        oc_latch_q;
  logic [$clog2(HICCUP_CYCLES+1)-1:0] hic_q;
  logic        pg_q;
  logic        sync_d_q;
  logic [15:0] scnt_q, sper_q, icnt_q, iper_q;
  logic        ext_q, sync_seen_q;

  // bus decode
  wire         wr_en   = psel & penable & pwrite;
  wire         setup   = psel & ~penable;
  wire         hit     = (paddr[1:0] == 2'b00) && (paddr <= OSF_OV_DLY);
  wire [15:0]  wd      = pwdata[15:0];
  wire         wr_ok   = wr_en & hit;
  wire         w_ctrl  = wr_ok && paddr == OSF_CTRL;
  wire         w_vcmd  = wr_ok && paddr == OSF_VCMD;
  wire         w_resp  = wr_ok && paddr == OSF_RESP;
  wire         w_stat  = wr_ok && paddr == OSF_STATUS;
  wire         en_rise = ctrl_q[CTRL_EN] & ~en_d1_q;
  wire         clr_any = w_stat | en_rise;

  // setpoint path: strap or written command, margin, trim, clamp
  wire [15:0]  nominal = cmd_wr_q ? vcmd_q : strap_q;
  wire [1:0]   mrg     = ctrl_q[CTRL_MRG +: 2];
  wire [15:0]  base    = (mrg == 2'd2) ? mhi_q :
                         (mrg == 2'd1) ? mlo_q : nominal;
  wire signed [17:0] sum = $signed({2'b00, base}) + $signed({{2{vtrim_q[15]}}, vtrim_q});
  wire [15:0]  trimmed = sum[17] ? 16'h0000 : (sum[16] ? 16'hFFFF : sum[15:0]);
  wire [15:0]  target  = (trimmed > vmax_q) ? vmax_q : trimmed;

  // fault comparators
  wire         running = ctrl_q[CTRL_EN] & output_on;
  wire [1:0]   vfault;
  // over-voltage is watched while enabled, so the auto response holds the loop off
  assign vfault[0] = ctrl_q[CTRL_EN] && vout_meas_mv > ovl_q;
  assign vfault[1] = running && ramp_done && vout_meas_mv < uvl_q;
  wire         ocf     = running && ramp_done && oc_detect;
  wire [1:0]   vresp [2];
  assign vresp[0] = resp_q[RESP_OV +: 2];
  assign vresp[1] = resp_q[RESP_UV +: 2];
  wire [1:0]   ocresp  = resp_q[RESP_OC +: 2];
  wire [1:0]   vblock;

  // per-channel voltage response: delayed, latched and auto shutdown
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_vch
      wire dly_hit = vfault[g] && vresp[g] == VR_DELAY && dly_q[g] >= ovdly_q;
      assign vblock[g] = shut_q[g] | (vfault[g] && vresp[g] == VR_AUTO);
      always_ff @(posedge clk) begin
        if (!rst_n || init_q) begin
          dly_q[g]  <= 16'h0000;
          shut_q[g] <= 1'b0;
        end else begin
          dly_q[g]  <= (vfault[g] && vresp[g] == VR_DELAY) ? dly_q[g] + 16'h0001 : 16'h0000;
          if (dly_hit || (vfault[g] && vresp[g] == VR_LATCH))
            shut_q[g] <= 1'b1;
          else if (clr_any)
            shut_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // over-current latch and hiccup timer
  wire oc_trip  = ocf && ocresp == CR_LATCH;
  wire hic_trip = ocf && ocresp == CR_HICCUP;
  wire hic_busy = hic_q != '0;
  always_ff @(posedge clk) begin
    if (!rst_n || init_q) begin
      oc_latch_q <= 1'b0;
      hic_q      <= '0;
    end else begin
      if (oc_trip)
        oc_latch_q <= 1'b1;
      else if (clr_any)
        oc_latch_q <= 1'b0;
      if (hic_trip && !hic_busy)
        hic_q <= ($clog2(HICCUP_CYCLES+1))'(HICCUP_CYCLES);
      else if (hic_busy)
        hic_q <= hic_q - 1'b1;
    end
  end

  // loop enable
  wire on_d = ctrl_q[CTRL_EN] & ~|vblock & ~oc_latch_q & ~hic_busy;
  wire any_fault = |vfault | ocf;

  // power good hysteresis
  wire pg_set = running && ramp_done && cal_done && !any_fault && vout_meas_mv >= pgon_q;
  wire pg_clr = !running || any_fault || vout_meas_mv < pgoff_q;
  always_ff @(posedge clk) begin
    if (!rst_n || init_q)
      pg_q <= 1'b0;
    else if (pg_clr)
      pg_q <= 1'b0;
    else if (pg_set)
      pg_q <= 1'b1;
  end

  // sync clock watch: edge period, presence, fallback frequency
  wire sync_edge = sync_in & ~sync_d_q;
  wire sync_lost = ext_q && !sync_seen_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_d_q    <= 1'b0;
      scnt_q      <= 16'h0000;
      sper_q      <= FREQ_RST;
      sync_seen_q <= 1'b0;
      ext_q       <= 1'b0;
    end else begin
      sync_d_q <= sync_in;
      if (sync_edge) begin
        scnt_q      <= 16'h0000;
        sper_q      <= scnt_q + 16'h0001;
        sync_seen_q <= 1'b1;
      end else if (scnt_q >= 16'(SYNC_CYCLES)) begin
        sync_seen_q <= 1'b0;
      end else begin
        scnt_q <= scnt_q + 16'h0001;
      end
      if (init_q || en_rise)
        ext_q <= sync_seen_q;
      else if (sync_lost)
        ext_q <= 1'b0;
    end
  end

  // internal oscillator divider, retuned to the lost sync period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      icnt_q <= 16'h0000;
      iper_q <= FREQ_RST;
    end else begin
      if (sync_lost)
        iper_q <= sper_q;
      else if ((init_q || en_rise) && !sync_seen_q)
        iper_q <= freq_q;
      icnt_q <= (icnt_q + 16'h0001 >= iper_q) ? 16'h0000 : icnt_q + 16'h0001;
    end
  end
  wire int_tick = icnt_q == 16'h0000;

  // register file with power-up defaults derived from nominal
  wire [15:0] nom_pu = nvm_vout_valid ? nvm_vout_mv : strap_vout_mv;
  wire [15:0] vmx_pu = (pct(nom_pu, PCT_VMAX) < VMAX_ABS_MV) ? pct(nom_pu, PCT_VMAX)
                                                              : VMAX_ABS_MV;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_q <= 1'b1;
      ctrl_q <= 3'h0;
      resp_q <= RESP_RST;
      freq_q <= FREQ_RST;
      ovdly_q <= OV_DLY_RST;
      cmd_wr_q <= 1'b0;
      en_d1_q <= 1'b0;
    end else begin
      init_q  <= 1'b0;
      en_d1_q <= ctrl_q[CTRL_EN];
      if (init_q) begin
        strap_q  <= nom_pu;
        vcmd_q   <= nom_pu;
        cmd_wr_q <= nvm_vout_valid;
        vtrim_q  <= 16'h0000;
        mhi_q    <= pct(nom_pu, PCT_MRG_HI);
        mlo_q    <= pct(nom_pu, PCT_MRG_LO);
        vmax_q   <= vmx_pu;
        ovl_q    <= pct(nom_pu, PCT_OV);
        uvl_q    <= pct(nom_pu, PCT_UV);
        pgon_q   <= pct(nom_pu, PCT_PG_ON);
        pgoff_q  <= pct(nom_pu, PCT_PG_OFF);
      end else if (wr_ok) begin
        case (paddr)
          OSF_CTRL:   ctrl_q  <= pwdata[2:0];
          OSF_VCMD:   vcmd_q  <= wd;
          OSF_VTRIM:  vtrim_q <= wd;
          OSF_MRG_HI: mhi_q   <= wd;
          OSF_MRG_LO: mlo_q   <= wd;
          OSF_VMAX:   vmax_q  <= wd;
          OSF_OV_LIM: ovl_q   <= wd;
          OSF_UV_LIM: uvl_q   <= wd;
          OSF_PG_ON:  pgon_q  <= wd;
          OSF_PG_OFF: pgoff_q <= wd;
          OSF_FREQ:   freq_q  <= (wd < 16'h0002) ? 16'h0002 : wd;
          OSF_OV_DLY: ovdly_q <= wd;
          default:    ;
        endcase
        if (w_vcmd)
          cmd_wr_q <= 1'b1;
        if (w_resp && pwdata[5:4] != 2'h3)
          resp_q <= pwdata[5:0];
        else if (w_resp)
          resp_q[3:0] <= pwdata[3:0];
      end
    end
  end

  // sticky flags: hardware set beats write-one clear
  osf_flags_t set_f;
  assign set_f = '{sync_lost: sync_lost, oc: ocf, uv: vfault[1], ov: vfault[0]};
  always_ff @(posedge clk) begin
    if (!rst_n)
      flags_q <= '0;
    else
      flags_q <= set_f | (flags_q & ~(w_stat ? pwdata[3:0] : 4'h0));
  end

  // outputs and loop drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_on      <= 1'b0;
      vout_target_mv <= 16'h0000;
      sw_tick        <= 1'b0;
    end else begin
      output_on      <= on_d;
      vout_target_mv <= target;
      sw_tick        <= ext_q ? sync_edge : int_tick;
    end
  end
  assign clk_sel_ext         = ext_q;
  assign supply_ok_output_o  = 1'b0;
  assign supply_ok_output_oe = ~pg_q;

  // read mux captured in the setup cycle
  wire [31:0] rmux =
    (paddr == OSF_CTRL)   ? {29'h0, ctrl_q} :
    (paddr == OSF_VCMD)   ? {16'h0, vcmd_q} :
    (paddr == OSF_VTRIM)  ? {16'h0, vtrim_q} :
    (paddr == OSF_MRG_HI) ? {16'h0, mhi_q} :
    (paddr == OSF_MRG_LO) ? {16'h0, mlo_q} :
    (paddr == OSF_VMAX)   ? {16'h0, vmax_q} :
    (paddr == OSF_OV_LIM) ? {16'h0, ovl_q} :
    (paddr == OSF_UV_LIM) ? {16'h0, uvl_q} :
    (paddr == OSF_PG_ON)  ? {16'h0, pgon_q} :
    (paddr == OSF_PG_OFF) ? {16'h0, pgoff_q} :
    (paddr == OSF_RESP)   ? {26'h0, resp_q} :
    (paddr == OSF_FREQ)   ? {16'h0, freq_q} :
    (paddr == OSF_STATUS) ? {26'h0, ext_q, pg_q, flags_q} :
    (paddr == OSF_TARGET) ? {16'h0, vout_target_mv} :
    (paddr == OSF_OV_DLY) ? {16'h0, ovdly_q} : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (!rst_n)
      prdata_q <= 32'h0000_0000;
    else if (setup)
      prdata_q <= hit ? rmux : 32'h0000_0000;
  end
  assign pready  = psel & penable;
  assign prdata  = prdata_q;
  assign pslverr = psel & penable & ~hit;

  // checks
  a_vcmd_kept: assert property (@(posedge clk) disable iff (!rst_n)
    w_vcmd && !init_q |=> vcmd_q == $past(wd)) else $error("command not stored as written");
  a_clamp_max: assert property (@(posedge clk) disable iff (!rst_n)
    !init_q |=> vout_target_mv <= $past(vmax_q)) else $error("target above clamp");
  a_trim_zero: assert property (@(posedge clk) disable iff (!rst_n)
    vtrim_q == 16'h0000 && mrg == 2'd0 && nominal <= vmax_q |=> vout_target_mv == $past(nominal))
    else $error("zero trim altered target");
  a_pg_fault: assert property (@(posedge clk) disable iff (!rst_n)
    any_fault |=> !pg_q) else $error("power good high during fault");
  a_pg_cal: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pg_q) |-> $past(cal_done) && $past(vout_meas_mv) >= $past(pgon_q))
    else $error("power good without calibration or threshold");
  a_oc_ramp: assert property (@(posedge clk) disable iff (!rst_n)
    !ramp_done && !flags_q.oc |=> !flags_q.oc) else $error("over-current seen during ramp");
  sequence s_ov_latch;
    vfault[0] && vresp[0] == VR_LATCH && !init_q;
  endsequence
  a_ov_latch: assert property (@(posedge clk) disable iff (!rst_n)
    s_ov_latch ##1 !clr_any |=> !output_on) else $error("latched shutdown missing");
  a_hiccup_off: assert property (@(posedge clk) disable iff (!rst_n)
    hic_trip && !hic_busy && !init_q |=> hic_busy ##1 !output_on)
    else $error("hiccup shutdown missing");
  a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    vfault[0] |=> flags_q.ov) else $error("over-voltage flag lost");
  a_sync_fall: assert property (@(posedge clk) disable iff (!rst_n)
    sync_lost |=> !ext_q && iper_q == $past(sper_q)) else $error("sync fallback wrong");
endmodule
`default_nettype wire

//--- dv/osf_sync_src.sv
// external sync clock source model that drives the sync pin
`timescale 1ns/1ps
`default_nettype none
module osf_sync_src #(
  parameter int HALF = 4
) (
  // clock and control
  input  wire logic clk,
  input  wire logic run,
  // sync pin
  output var  logic sync_out
);
  int cnt;

  // toggles every HALF cycles while running, stands still low otherwise
  always @(posedge clk) begin
    if (!run) begin
      sync_out <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      sync_out <= ~sync_out;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- dv/output_supervisor_fault_ctrl_tb_top.sv
// self-checking testbench for the output supervisor block
`timescale 1ns/1ps
`default_nettype none
module output_supervisor_fault_ctrl_tb_top import osf_pkg::*; ;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] strap_mv, nvm_mv, vout_mv, target_mv;
  logic        nvm_ok, oc, ramp, cal, sync_run, sync_pin, out_on, ext_sel, tick, pg_o, pg_oe;
  wire         pg_line;
  int          err_count, checked, n, k;

  // open-drain power good with its pull-up
  assign pg_line = pg_oe ? pg_o : 1'b1;

  // design under test with short hiccup and sync-loss counts
  osf_supervisor #(.HICCUP_CYCLES(20), .SYNC_CYCLES(16)) i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .strap_vout_mv(strap_mv), .nvm_vout_valid(nvm_ok), .nvm_vout_mv(nvm_mv),
    .vout_meas_mv(vout_mv), .oc_detect(oc), .ramp_done(ramp), .cal_done(cal),
    .sync_in(sync_pin), .vout_target_mv(target_mv), .output_on(out_on),
    .clk_sel_ext(ext_sel), .sw_tick(tick), .supply_ok_output_o(pg_o),
    .supply_ok_output_oe(pg_oe));

  // far-side sync source
  osf_sync_src #(.HALF(4)) i_sync (.clk(clk), .run(sync_run), .sync_out(sync_pin));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one apb transfer: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && t < 16) begin
      @(posedge clk);
      t++;
    end
    if (t == 16) chk(32'h0, 32'h1, "apb no ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask

  // waits a bounded time for loop enable (sel 0) or sync select (sel 1)
  task automatic wait_lvl(input logic sel, input logic v, input int max, output int c);
    c = 0;
    while ((sel ? ext_sel : out_on) !== v && c < max) begin
      @(posedge clk);
      c++;
    end
    chk(32'(sel ? ext_sel : out_on), 32'(v), "level wait");
  endtask

  task automatic do_reset(input logic valid, input logic [15:0] mv);
    rst_n <= 1'b0;
    nvm_ok <= valid;
    nvm_mv <= mv;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_defaults();
    chk(32'(pg_line), 32'h0, "pg at start");
    chk(32'(ext_sel), 32'h0, "no sync");
    rdc(OSF_MRG_HI, 32'h0000_041A);
    rdc(OSF_MRG_LO, 32'h0000_03B6);
    rdc(OSF_VMAX, 32'h0000_044C);
    rdc(OSF_OV_LIM, 32'h0000_047E);
    rdc(OSF_UV_LIM, 32'h0000_0352);
    rdc(OSF_PG_ON, 32'h0000_0384);
    rdc(OSF_PG_OFF, 32'h0000_0352);
    rdc(OSF_RESP, 32'h0000_002F);
    rdc(OSF_TARGET, 32'h0000_03E8);
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'(er), 32'h1, "unmapped");
  endtask

  task automatic t_setpoint();
    wr(OSF_VCMD, 32'h0000_04B0);
    rdc(OSF_TARGET, 32'h0000_044C);
    rdc(OSF_VCMD, 32'h0000_04B0);
    wr(OSF_VMAX, 32'h0000_07D0);
    rdc(OSF_TARGET, 32'h0000_04B0);
    wr(OSF_VTRIM, 32'h0000_FFCE);
    rdc(OSF_TARGET, 32'h0000_047E);
    chk(32'(target_mv), 32'h0000_047E, "target pin");
    wr(OSF_VTRIM, 32'h0);
    rdc(OSF_TARGET, 32'h0000_04B0);
  endtask

  task automatic t_margin();
    wr(OSF_CTRL, 32'h4);
    rdc(OSF_TARGET, 32'h0000_041A);
    wr(OSF_CTRL, 32'h2);
    rdc(OSF_TARGET, 32'h0000_03B6);
    wr(OSF_MRG_HI, 32'h0000_0514);
    wr(OSF_CTRL, 32'h4);
    rdc(OSF_TARGET, 32'h0000_0514);
    wr(OSF_CTRL, 32'h0);
    rdc(OSF_TARGET, 32'h0000_04B0);
  endtask

  task automatic t_pgood();
    wr(OSF_VCMD, 32'h0000_03E8);
    wr(OSF_PG_OFF, 32'h0000_0384);
    wr(OSF_PG_ON, 32'h0000_03B6);
    vout_mv <= 16'h03D4;
    ramp <= 1'b1;
    wr(OSF_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    chk(32'(pg_line), 32'h0, "pg without cal");
    cal <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(pg_line), 32'h1, "pg up");
    vout_mv <= 16'h0370;
    repeat (3) @(posedge clk);
    chk(32'(pg_line), 32'h0, "pg below off");
    vout_mv <= 16'h0398;
    repeat (3) @(posedge clk);
    chk(32'(pg_line), 32'h0, "pg below on");
    vout_mv <= 16'h03D4;
    repeat (3) @(posedge clk);
    chk(32'(pg_line), 32'h1, "pg again");
  endtask

  // over-voltage fault under response code r, then recovery
  task automatic ov_case(input logic [31:0] r);
    wr(OSF_RESP, r);
    vout_mv <= 16'h04B0;
    case (r[1:0])
      VR_AUTO: begin
        wait_lvl(1'b0, 1'b0, 5, n);
        chk(32'(pg_line), 32'h0, "pg in fault");
        vout_mv <= 16'h03D4;
        wait_lvl(1'b0, 1'b1, 5, n);
      end
      VR_LATCH: begin
        wait_lvl(1'b0, 1'b0, 5, n);
        vout_mv <= 16'h03D4;
        repeat (10) @(posedge clk);
        chk(32'(out_on), 32'h0, "latched");
        wr(OSF_STATUS, 32'h0);
        wait_lvl(1'b0, 1'b1, 5, n);
      end
      VR_DELAY: begin
        wait_lvl(1'b0, 1'b0, 20, n);
        chk(32'(n >= 8 && n <= 14), 32'h1, "delay span");
        vout_mv <= 16'h03D4;
        wr(OSF_STATUS, 32'h0);
        wait_lvl(1'b0, 1'b1, 5, n);
      end
      default: begin
        repeat (12) @(posedge clk);
        chk(32'(out_on), 32'h1, "ignored");
        vout_mv <= 16'h03D4;
      end
    endcase
    apb(1'b0, OSF_STATUS, 32'h0);
    if (r[1:0] != VR_IGNORE) chk(32'(rd[0]), 32'h1, "ov flag");
    wr(OSF_STATUS, 32'hF);
  endtask

  task automatic t_voltage();
    wr(OSF_OV_DLY, 32'h0000_000A);
    ov_case(32'h0000_002F);
    ov_case(32'h0000_002E);
    ov_case(32'h0000_002D);
    ov_case(32'h0000_002C);
    wr(OSF_RESP, 32'h0000_002F);
    vout_mv <= 16'h0320;
    wait_lvl(1'b0, 1'b0, 5, n);
    vout_mv <= 16'h03D4;
    wait_lvl(1'b0, 1'b1, 5, n);
    apb(1'b0, OSF_STATUS, 32'h0);
    chk(32'(rd[1]), 32'h1, "uv flag");
    wr(OSF_STATUS, 32'hF);
  endtask

  task automatic t_current();
    ramp <= 1'b0;
    oc <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(out_on), 32'h1, "oc in ramp");
    ramp <= 1'b1;
    wait_lvl(1'b0, 1'b0, 5, n);
    oc <= 1'b0;
    wait_lvl(1'b0, 1'b1, 40, n);
    chk(32'(n >= 10 && n <= 25), 32'h1, "hiccup span");
    wr(OSF_STATUS, 32'hF);
    wr(OSF_RESP, 32'h0000_001F);  // host sets over-current fault response to latch
    oc <= 1'b1;
    wait_lvl(1'b0, 1'b0, 5, n);
    oc <= 1'b0;
    repeat (40) @(posedge clk);
    chk(32'(out_on), 32'h0, "oc latched");
    apb(1'b0, OSF_STATUS, 32'h0);
    chk(32'(rd[2]), 32'h1, "oc flag");
    wr(OSF_CTRL, 32'h0);
    wr(OSF_CTRL, 32'h1);
    wait_lvl(1'b0, 1'b1, 5, n);
    wr(OSF_RESP, 32'h0000_003F);
    rdc(OSF_RESP, 32'h0000_001F);
    wr(OSF_RESP, 32'h0000_000F);
    oc <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(out_on), 32'h1, "oc ignored");
    oc <= 1'b0;
    wr(OSF_STATUS, 32'hF);
  endtask

  task automatic t_sync();
    sync_run <= 1'b1;  // sync stable before the output is enabled
    repeat (20) @(posedge clk);
    wr(OSF_CTRL, 32'h0);
    wr(OSF_CTRL, 32'h1);
    wait_lvl(1'b1, 1'b1, 60, n);
    apb(1'b0, OSF_STATUS, 32'h0);
    chk(32'(rd[5]), 32'h1, "ext selected");
    sync_run <= 1'b0;
    wait_lvl(1'b1, 1'b0, 40, n);
    rdc(OSF_FREQ, 32'h0000_00C8);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (tick === 1'b1) k++;
    end
    chk(32'(k >= 4 && k <= 6), 32'h1, "internal ticks");
    apb(1'b0, OSF_STATUS, 32'h0);
    chk(32'(rd[3]), 32'h1, "sync lost flag");
    wr(OSF_FREQ, 32'h0000_0001);
    rdc(OSF_FREQ, 32'h0000_0002);
    wr(OSF_FREQ, 32'h0000_0014);  // host would revisit loop settings on this retune
    wr(OSF_CTRL, 32'h0);
    wr(OSF_CTRL, 32'h1);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (tick === 1'b1) k++;
    end
    chk(32'(k >= 1 && k <= 3), 32'h1, "configured period ticks");
  endtask

  task automatic t_stored();
    do_reset(1'b1, 16'h1450);
    rdc(OSF_TARGET, 32'h0000_1450);
    rdc(OSF_VMAX, 32'h0000_157C);
  endtask

  // watchdog cuts a hang short
  initial begin
    #100_000;
    err_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    err_count = 0;
    checked = 0;
    {rst_n, psel, penable, pwrite, nvm_ok, oc, ramp, cal, sync_run} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap_mv = 16'h03E8;
    nvm_mv = 16'h0000;
    vout_mv = 16'h0000;
    do_reset(1'b0, 16'h0000);
    t_defaults();
    t_setpoint();
    t_margin();
    t_pgood();
    t_voltage();
    t_current();
    t_sync();
    t_stored();
    report_and_stop();
  end
endmodule
`default_nettype wire
